/* common/srs_map.svh */
/*
  Constants for the speed reference selector: function codes, setting codes,
  factory defaults and timing counts. Assumes a 40 MHz core clock.
*/
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH
`define SRS_FN_STEP1        6'h06
`define SRS_FN_STEP2        6'h07
`define SRS_FN_STEP3        6'h08
`define SRS_FN_STEP4        6'h20
`define SRS_FN_JOG          6'h0a
`define SRS_FN_RAMP1        6'h0b
`define SRS_FN_RAMP2        6'h1b
`define SRS_N_INPUTS        7
`define SRS_SRC_ANALOG      1'h1
`define SRS_PCT_FULL        8'h64
`define SRS_ADC_FULL        10'h3ff
`define SRS_JOG_DEFAULT     16'h0258
`define SRS_GAIN_DEFAULT    8'h64
`define SRS_BIAS_DEFAULT    8'h00
`define SRS_UPPER_DEFAULT   8'h64
`define SRS_LOWER_DEFAULT   8'h00
`define SRS_COARSE_LIMIT    16'h1770
`define SRS_RIDE_NONE       2'h0
`define SRS_RIDE_TIMED      2'h1
`define SRS_RIDE_HOLD       2'h2
`define SRS_RIDE_TIME_MS    500
`define SRS_CLK_KHZ         40000
`define SRS_RIDE_CYCLES     (`SRS_RIDE_TIME_MS * `SRS_CLK_KHZ)
`endif

/* common/srs_pkg.sv */
/*
  Types shared by the speed reference selector.
  Assumes the map header supplies all numeric constants.
*/
package srs_pkg;
  typedef enum logic [1:0] {
    srs_idle,
    srs_run,
    srs_lost,
    srs_fault
  } srs_ride_e;
  typedef logic [15:0] srs_freq_t;
endpackage

/* rtl/srs_selector.sv */
/*
  Speed reference selector: picks the frequency reference and ramp pair from
  run, jog and contact inputs, clamps it, and handles momentary power loss.
  Assumes all inputs are synchronous to core_clk and settings are static words.
  Frequencies are in 0.01 Hz; ramp times in the unit of the time-unit setting.
*/
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.svh"
module srs_selector #(
  parameter int unsigned RIDE_CYCLES = `SRS_RIDE_CYCLES  // power loss window
) (
  input  wire logic                core_clk,              // control clock
  input  wire logic                reset_n,               // sync reset, low
  input  wire logic                fwd_run_cmd,           // forward run request
  input  wire logic                rev_run_cmd,           // reverse run request
  input  wire logic [6:0]          contact_inputs,        // multi-function inputs
  input  wire logic [41:0]         input_function_codes,  // 6 bits per input
  input  wire logic                reverse_prohibit_sel,  // 1 blocks reverse
  input  wire logic                reference_source_sel,  // 1 analog, 0 keypad
  input  wire logic [15:0]         keypad_ref,            // keypad reference
  input  wire logic [127:0]        preset_refs_lower_bank, // presets 1..7
  input  wire logic [127:0]        preset_refs_upper_bank, // presets 8..15
  input  wire logic                jog_freq_wr,           // write jog frequency
  input  wire logic [15:0]         jog_freq_wdata,        // new jog frequency
  input  wire logic [9:0]          analog_ref_pin,        // analog sample
  input  wire logic [7:0]          analog_gain,           // percent
  input  wire logic [7:0]          analog_bias,           // percent
  input  wire logic [7:0]          ref_upper_limit,       // percent
  input  wire logic [7:0]          ref_lower_limit,       // percent
  input  wire logic [15:0]         min_output_frequency,  // 0.01 Hz
  input  wire logic [15:0]         max_output_frequency,  // 0.01 Hz
  input  wire logic [127:0]        ramp_times,            // acc/dec 1..4
  input  wire logic                unit_wr,               // write time unit
  input  wire logic                unit_wdata,            // new time unit
  input  wire logic                motor_stopped,         // output at rest
  input  wire logic [1:0]          ridethrough_sel,       // ridethrough mode
  input  wire logic                power_ok,              // main supply present
  input  wire logic                control_power_ok,      // control supply held
  output logic                     run_ff,                // motor may run
  output logic                     reverse_ff,            // direction reverse
  output srs_pkg::srs_freq_t       freq_ref_ff,           // active reference
  output logic [1:0]               ramp_pair_ff,          // pair index 0..3
  output logic [15:0]              accel_time_ff,         // selected accel
  output logic [15:0]              decel_time_ff,         // selected decel
  output logic                     ramp_time_unit_sel,    // 1 fine, 0 coarse
  output logic [15:0]              jog_frequency,         // jog setting
  output logic                     unit_refused_ff,       // unit write refused
  output logic                     fault_ff               // power loss fault
);

  logic [6:0] is_step1, is_step2, is_step3, is_step4, is_jog, is_ramp1, is_ramp2;
  logic       step1, step2, step3, step4, jog, ramp1, ramp2;
  logic       long_ramp;
  logic       ramp_time_unit_sel_ff;
  logic [15:0] jog_frequency_ff;
  srs_pkg::srs_ride_e ride_ff;
  logic [31:0] lost_cnt_ff;

  genvar gi;
  generate
    for (gi = 0; gi < `SRS_N_INPUTS; gi++) begin : g_in
      logic [5:0] fc;
      assign fc = input_function_codes[gi*6 +: 6];
      assign is_step1[gi] = contact_inputs[gi] && (fc == `SRS_FN_STEP1);
      assign is_step2[gi] = contact_inputs[gi] && (fc == `SRS_FN_STEP2);
      assign is_step3[gi] = contact_inputs[gi] && (fc == `SRS_FN_STEP3);
      assign is_step4[gi] = contact_inputs[gi] && (fc == `SRS_FN_STEP4);
      assign is_jog[gi]   = contact_inputs[gi] && (fc == `SRS_FN_JOG);
      assign is_ramp1[gi] = contact_inputs[gi] && (fc == `SRS_FN_RAMP1);
      assign is_ramp2[gi] = contact_inputs[gi] && (fc == `SRS_FN_RAMP2);
    end
  endgenerate

  assign step1 = |is_step1;
  assign step2 = |is_step2;
  assign step3 = |is_step3;
  assign step4 = |is_step4;
  assign jog   = |is_jog;
  assign ramp1 = |is_ramp1;
  assign ramp2 = |is_ramp2;

  // analog scaling: bias at zero input, gain at full scale, percent of max
  logic signed [19:0] pct_span;
  logic        [29:0] pct_x;
  logic        [19:0] pct_scaled;
  logic        [27:0] ana_wide;
  logic        [15:0] ana_ref;
  always_comb begin
    pct_span = 20'(signed'({1'b0, analog_gain})) - 20'(signed'({1'b0, analog_bias}));
    pct_x = 30'(unsigned'(pct_span < 0 ? -pct_span : pct_span)) * 30'(analog_ref_pin);
    pct_scaled = 20'(pct_x / 30'(`SRS_ADC_FULL));
    if (pct_span < 0) begin
      ana_wide = (pct_scaled > 20'(analog_bias)) ? 28'h0 :
                 28'(20'(analog_bias) - pct_scaled) * 28'(max_output_frequency);
    end else begin
      ana_wide = 28'(20'(analog_bias) + pct_scaled) * 28'(max_output_frequency);
    end
    ana_ref = ((ana_wide / 28'(`SRS_PCT_FULL)) > 28'hffff) ? 16'hffff :
              16'(ana_wide / 28'(`SRS_PCT_FULL));
  end

  // source select, jog first, then multi-step, then base source
  logic [3:0]  step_idx;
  logic [15:0] raw_ref, upper_f, lower_f, clamped;
  assign step_idx = {step4, step3, step2, step1};
  always_comb begin
    if (jog) begin
      raw_ref = jog_frequency_ff;
    end else if (step4) begin
      raw_ref = preset_refs_upper_bank[step_idx[2:0]*16 +: 16];
    end else if (|step_idx[2:0]) begin
      raw_ref = preset_refs_lower_bank[step_idx[2:0]*16 +: 16];
    end else if (reference_source_sel == `SRS_SRC_ANALOG) begin
      raw_ref = ana_ref;
    end else begin
      raw_ref = keypad_ref;
    end
    upper_f = 16'((24'(ref_upper_limit) * 24'(max_output_frequency)) / 24'(`SRS_PCT_FULL));
    lower_f = 16'((24'(ref_lower_limit) * 24'(max_output_frequency)) / 24'(`SRS_PCT_FULL));
    if (raw_ref > upper_f) begin
      clamped = upper_f;
    end else if (raw_ref < lower_f) begin
      clamped = lower_f;
    end else begin
      clamped = raw_ref;
    end
  end

  // ramp times above the coarse-to-fine boundary
  always_comb begin
    long_ramp = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (ramp_times[i*16 +: 16] > `SRS_COARSE_LIMIT) begin
        long_ramp = 1'b1;
      end
    end
  end

  logic fwd_ok, rev_ok, any_run, nxt_run;
  assign fwd_ok  = fwd_run_cmd && !rev_run_cmd;
  assign rev_ok  = rev_run_cmd && !fwd_run_cmd && !reverse_prohibit_sel;
  assign any_run = fwd_ok || rev_ok;
  // run drops during a ride interval and returns with the run state and supply
  assign nxt_run = any_run && (ride_ff == srs_pkg::srs_run) && power_ok
                   && (lower_f >= min_output_frequency);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ramp_time_unit_sel_ff <= 1'b0;
      unit_refused_ff       <= 1'b0;
    end else begin
      unit_refused_ff <= 1'b0;
      if (unit_wr) begin
        if (!motor_stopped) begin
          unit_refused_ff <= 1'b1;
        end else if (unit_wdata && !ramp_time_unit_sel_ff && long_ramp) begin
          unit_refused_ff <= 1'b1;
        end else begin
          ramp_time_unit_sel_ff <= unit_wdata;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      jog_frequency_ff <= `SRS_JOG_DEFAULT;
    end else if (jog_freq_wr) begin
      jog_frequency_ff <= jog_freq_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ride_ff     <= srs_pkg::srs_run;
      lost_cnt_ff <= 32'h0;
      fault_ff    <= 1'b0;
    end else begin
      unique case (ride_ff)
        srs_pkg::srs_idle, srs_pkg::srs_run: begin
          ride_ff <= srs_pkg::srs_run;
          if (!power_ok && any_run) begin
            lost_cnt_ff <= 32'h0;
            if (ridethrough_sel == `SRS_RIDE_NONE) begin
              ride_ff  <= srs_pkg::srs_fault;
              fault_ff <= 1'b1;
            end else begin
              ride_ff <= srs_pkg::srs_lost;
            end
          end
        end
        srs_pkg::srs_lost: begin
          lost_cnt_ff <= lost_cnt_ff + 32'h1;
          if (!any_run) begin
            ride_ff <= srs_pkg::srs_fault;
            fault_ff <= (ridethrough_sel != `SRS_RIDE_HOLD);
          end else if (ridethrough_sel == `SRS_RIDE_HOLD) begin
            if (!control_power_ok) begin
              ride_ff <= srs_pkg::srs_fault;
            end else if (power_ok) begin
              ride_ff <= srs_pkg::srs_run;
            end
          end else if (power_ok && lost_cnt_ff < RIDE_CYCLES) begin
            ride_ff <= srs_pkg::srs_run;
          end else if (lost_cnt_ff >= RIDE_CYCLES) begin
            ride_ff  <= srs_pkg::srs_fault;
            fault_ff <= 1'b1;
          end
        end
        srs_pkg::srs_fault: begin
          if (!any_run && power_ok) begin
            ride_ff  <= srs_pkg::srs_idle;
            fault_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      run_ff        <= 1'b0;
      reverse_ff    <= 1'b0;
      freq_ref_ff   <= 16'h0;
      ramp_pair_ff  <= 2'h0;
      accel_time_ff <= 16'h0;
      decel_time_ff <= 16'h0;
    end else begin
      run_ff        <= nxt_run;
      if (any_run) begin
        reverse_ff  <= rev_ok;
      end
      freq_ref_ff   <= clamped;
      ramp_pair_ff  <= {ramp2, ramp1};
      // each time spans 0 to 100% of max frequency
      accel_time_ff <= ramp_times[{ramp2, ramp1, 1'b0}*16 +: 16];
      decel_time_ff <= ramp_times[{ramp2, ramp1, 1'b1}*16 +: 16];
    end
  end

  assign ramp_time_unit_sel = ramp_time_unit_sel_ff;
  assign jog_frequency      = jog_frequency_ff;

endmodule // srs_selector
`default_nettype wire

/* sim/srs_selector_props.sv */
/* srs_selector_props: concurrent checks on the selector ports.
   assumes one core_clk domain; bound to every srs_selector below */
`timescale 1ns/1ps
`default_nettype none
module srs_selector_props (
  input wire logic         core_clk,             // clock
  input wire logic         reset_n,              // sync reset
  input wire logic         fwd_run_cmd,          // forward
  input wire logic         rev_run_cmd,          // reverse
  input wire logic         reverse_prohibit_sel, // reverse block
  input wire logic         jog_freq_wr,          // jog write
  input wire logic [15:0]  jog_freq_wdata,       // jog value
  input wire logic [127:0] ramp_times,           // ramp words
  input wire logic         unit_wr,              // unit write
  input wire logic         unit_wdata,           // unit value
  input wire logic         motor_stopped,        // at rest
  input wire logic [1:0]   ridethrough_sel,      // ride mode
  input wire logic         power_ok,             // supply
  input wire logic         run_ff,               // run
  input wire logic [1:0]   ramp_pair_ff,         // pair
  input wire logic [15:0]  accel_time_ff,        // accel
  input wire logic         ramp_time_unit_sel,   // unit
  input wire logic [15:0]  jog_frequency,        // jog
  input wire logic         unit_refused_ff,      // refused
  input wire logic         fault_ff              // fault
);
  logic [127:0] ramp_times_ff;
  always_ff @(posedge core_clk) begin
    ramp_times_ff <= ramp_times;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  a_rev_blocked: assert property (
    rev_run_cmd && !fwd_run_cmd && reverse_prohibit_sel |=> !run_ff)
    else $error("reverse run accepted while prohibited");
  a_unit_refused: assert property (
    unit_wr && !motor_stopped |=> unit_refused_ff && $stable(ramp_time_unit_sel))
    else $error("unit change taken while running");
  a_unit_taken: assert property (
    unit_wr && motor_stopped && !unit_wdata |=> !unit_refused_ff && !ramp_time_unit_sel)
    else $error("unit change to coarse not taken while stopped");
  a_accel_pair: assert property (
    $past(reset_n) |-> accel_time_ff == ramp_times_ff[{ramp_pair_ff, 5'h00} +: 16])
    else $error("accel time not from selected pair");
  a_jog_write: assert property (
    jog_freq_wr |=> jog_frequency == $past(jog_freq_wdata))
    else $error("jog frequency write lost");
  a_hold_no_fault: assert property (
    $rose(fault_ff) |-> $past(ridethrough_sel) != 2'h2)
    else $error("fault raised in hold ridethrough mode");
  a_loss_fault: assert property (
    run_ff && !power_ok && ridethrough_sel == 2'h0 |-> ##[1:2] fault_ff)
    else $error("power loss without fault in mode 0");
  a_loss_stop: assert property (
    !power_ok |=> !run_ff)
    else $error("running without supply");
  cover property (unit_refused_ff);
  cover property ($rose(fault_ff));
  cover property (jog_freq_wr);
endmodule // srs_selector_props
bind srs_selector srs_selector_props u_srs_selector_props (
  .core_clk, .reset_n, .fwd_run_cmd, .rev_run_cmd, .reverse_prohibit_sel, .jog_freq_wr,
  .jog_freq_wdata, .ramp_times, .unit_wr, .unit_wdata, .motor_stopped, .ridethrough_sel,
  .power_ok, .run_ff, .ramp_pair_ff, .accel_time_ff, .ramp_time_unit_sel, .jog_frequency,
  .unit_refused_ff, .fault_ff);
`default_nettype wire

/* sim/srs_terminal_model.sv */
/* srs_terminal_model: run contacts of the control terminals.
   assumes the operator side changes its wishes at the falling edge */
`timescale 1ns/1ps
`default_nettype none
module srs_terminal_model (
  input  wire logic want_fwd,    // operator forward
  input  wire logic want_rev,    // operator reverse
  output wire logic fwd_run_cmd, // forward contact
  output wire logic rev_run_cmd  // reverse contact
);
  // contacts are levels, kept closed through supply dips
  assign fwd_run_cmd = want_fwd;
  assign rev_run_cmd = want_rev;
endmodule // srs_terminal_model
`default_nettype wire

/* sim/tb_srs_selector.sv */
/* tb_srs_selector: scenario bench for the speed reference selector.
   assumes srs_pkg and srs_map.svh; inputs change at the falling edge */
`timescale 1ns/1ps
`default_nettype none
`include "srs_map.svh"
module tb_srs_selector;
  logic         core_clk = 1'b0, reset_n = 1'b0, want_fwd = 1'b0, want_rev = 1'b0;
  logic         reverse_prohibit_sel = 1'b0, reference_source_sel = 1'b0, jog_freq_wr = 1'b0;
  logic         unit_wr = 1'b0, unit_wdata = 1'b0, motor_stopped = 1'b1, power_ok = 1'b1;
  logic         control_power_ok = 1'b1, fwd_run_cmd, rev_run_cmd, run_ff, reverse_ff;
  logic         ramp_time_unit_sel, unit_refused_ff, fault_ff;
  logic [1:0]   ridethrough_sel = 2'h0, ramp_pair_ff;
  logic [6:0]   contact_inputs = 7'h00;
  logic [7:0]   analog_gain = 8'h64, analog_bias = 8'h00, ref_upper_limit = 8'h64;
  logic [7:0]   ref_lower_limit = 8'h05;
  logic [9:0]   analog_ref_pin = 10'h000;
  logic [15:0]  keypad_ref = 16'h0800, jog_freq_wdata = 16'h0000;
  logic [15:0]  min_output_frequency = 16'h0096, max_output_frequency = 16'h1770;
  logic [15:0]  accel_time_ff, decel_time_ff, jog_frequency;
  logic [41:0]  input_function_codes = {`SRS_FN_RAMP2, `SRS_FN_RAMP1, `SRS_FN_JOG,
                  `SRS_FN_STEP4, `SRS_FN_STEP3, `SRS_FN_STEP2, `SRS_FN_STEP1};
  logic [127:0] preset_refs_lower_bank, preset_refs_upper_bank, ramp_times;
  srs_pkg::srs_freq_t freq_ref_ff;
  int           errors = 0, n_checks = 0, cyc = 0;
  srs_terminal_model u_srs_terminal_model (.want_fwd, .want_rev, .fwd_run_cmd, .rev_run_cmd);
  srs_selector #(.RIDE_CYCLES(50)) u_srs_selector (.core_clk, .reset_n, .fwd_run_cmd,
    .rev_run_cmd, .contact_inputs, .input_function_codes, .reverse_prohibit_sel,
    .reference_source_sel, .keypad_ref, .preset_refs_lower_bank, .preset_refs_upper_bank,
    .jog_freq_wr, .jog_freq_wdata, .analog_ref_pin, .analog_gain, .analog_bias,
    .ref_upper_limit, .ref_lower_limit, .min_output_frequency, .max_output_frequency,
    .ramp_times, .unit_wr, .unit_wdata, .motor_stopped, .ridethrough_sel, .power_ok,
    .control_power_ok, .run_ff, .reverse_ff, .freq_ref_ff, .ramp_pair_ff, .accel_time_ff,
    .decel_time_ff, .ramp_time_unit_sel, .jog_frequency, .unit_refused_ff, .fault_ff);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step();
    @(negedge core_clk);
  endtask
  task automatic t_steps();
    logic [15:0] exp;
    want_fwd = 1'b1;
    for (int k = 0; k < 16; k++) begin
      contact_inputs = {3'h0, 4'(k)};
      exp = k[3] ? preset_refs_upper_bank[16*k-128 +: 16] : preset_refs_lower_bank[16*k +: 16];
      if (k == 0) exp = keypad_ref;
      step();
      chk("step ref", exp, freq_ref_ff);
      chk("step run", 16'h0001, 16'(run_ff));
    end
  endtask
  task automatic t_jog_clamp();
    contact_inputs = 7'h17;
    step();
    chk("jog over steps", `SRS_JOG_DEFAULT, freq_ref_ff);
    jog_freq_wr = 1'b1;
    jog_freq_wdata = 16'h03e8;
    step();
    jog_freq_wr = 1'b0;
    chk("jog setting", 16'h03e8, jog_frequency);
    step();
    chk("jog ref", 16'h03e8, freq_ref_ff);
    contact_inputs = 7'h00;
    keypad_ref = 16'h1f40;
    ref_upper_limit = 8'h32;
    step();
    chk("upper clamp", 16'h0bb8, freq_ref_ff);
    keypad_ref = 16'h0000;
    step();
    chk("lower clamp", 16'h012c, freq_ref_ff);
    ref_lower_limit = 8'h02;
    step();
    chk("below min run", 16'h0000, 16'(run_ff));
    ref_lower_limit = 8'h05;
    ref_upper_limit = 8'h64;
    reference_source_sel = 1'b1;
    analog_ref_pin = 10'h3ff;
    step();
    chk("analog gain", 16'h1770, freq_ref_ff);
    analog_ref_pin = 10'h000;
    analog_bias = 8'h0a;
    step();
    chk("analog bias", 16'h0258, freq_ref_ff);
    reference_source_sel = 1'b0;
    keypad_ref = 16'h0800;
  endtask
  task automatic t_rev_ramp();
    want_fwd = 1'b0;
    want_rev = 1'b1;
    reverse_prohibit_sel = 1'b1;
    step();
    chk("rev blocked", 16'h0000, 16'(run_ff));
    reverse_prohibit_sel = 1'b0;
    step();
    chk("rev run", 16'h0003, 16'({run_ff, reverse_ff}));
    want_rev = 1'b0;
    want_fwd = 1'b1;
    for (int p = 0; p < 4; p++) begin
      contact_inputs = {2'(p), 5'h00};
      step();
      chk("pair", 16'(p), 16'(ramp_pair_ff));
      chk("accel", ramp_times[32*p +: 16], accel_time_ff);
      chk("decel", ramp_times[32*p+16 +: 16], decel_time_ff);
    end
  endtask
  task automatic unit_try(input logic d, input logic stopped, input logic [1:0] exp);
    motor_stopped = stopped;
    unit_wdata = d;
    unit_wr = 1'b1;
    step();
    unit_wr = 1'b0;
    chk("refused and unit", 16'(exp), 16'({unit_refused_ff, ramp_time_unit_sel}));
    step();
    chk("refused pulse end", 16'h0000, 16'(unit_refused_ff));
  endtask
  task automatic ride(input logic [1:0] sel, input int gap, input logic [1:0] exp);
    ridethrough_sel = sel;
    power_ok = 1'b0;
    repeat (gap) step();
    power_ok = 1'b1;
    repeat (3) step();
    chk("fault and run", 16'(exp), 16'({fault_ff, run_ff}));
    want_fwd = 1'b0;
    repeat (3) step();
    want_fwd = 1'b1;
    repeat (2) step();
  endtask
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    for (int k = 0; k < 8; k++) begin
      preset_refs_lower_bank[16*k +: 16] = 16'h1000 + 16'(k);
      preset_refs_upper_bank[16*k +: 16] = 16'h1200 + 16'(k);
      ramp_times[32*k +: 32] = {16'h0070 + 16'(k), 16'h0064 + 16'(k)};
    end
    repeat (3) @(negedge core_clk);
    chk("reset jog", `SRS_JOG_DEFAULT, jog_frequency);
    chk("reset outs", 16'h0000, 16'({run_ff, ramp_time_unit_sel, fault_ff}));
    reset_n = 1'b1;
    t_steps();
    t_jog_clamp();
    t_rev_ramp();
    unit_try(1'b1, 1'b0, 2'h2);
    unit_try(1'b1, 1'b1, 2'h1);
    unit_try(1'b0, 1'b1, 2'h0);
    ramp_times[15:0] = 16'h1771;
    unit_try(1'b1, 1'b1, 2'h2);
    ramp_times[15:0] = 16'h0064;
    ride(2'h0, 5, 2'h2);
    ride(2'h1, 10, 2'h1);
    ride(2'h1, 60, 2'h2);
    ride(2'h2, 60, 2'h1);
    end_of_test();
  end
endmodule // tb_srs_selector
`default_nettype wire
